//--- inc/fsd_pkg.sv
// Package of constants for the sine-cosine and hyperbolic sine decoder
package fsd_pkg;
    // APB register byte offsets
    localparam logic [7:0] FSD_OFF_OPWORD = 8'h00;
    localparam logic [7:0] FSD_OFF_CMD = 8'h04;
    localparam logic [7:0] FSD_OFF_EA = 8'h08;
    localparam logic [7:0] FSD_OFF_SRC = 8'h0C;
    localparam logic [7:0] FSD_OFF_DECODE = 8'h10;
    localparam logic [7:0] FSD_OFF_FP_STATUS_REGISTER = 8'h14;
    localparam logic [7:0] FSD_OFF_IRQ_STAT = 8'h18;
    localparam logic [7:0] FSD_OFF_IRQ_MASK = 8'h1C;
    localparam logic [7:0] FSD_OFF_CPID = 8'h20;
    // Command word field positions
    localparam int FSD_RM_BIT = 14;
    localparam int FSD_SPEC_LSB = 10;
    localparam int FSD_DST_LSB = 7;
    localparam int FSD_COS_LSB = 0;
    localparam logic [3:0] FSD_OPM_SINCOS = 4'h6;
    localparam logic [6:0] FSD_OPM_SINH = 7'h02;
    // Source formats
    localparam logic [2:0] FSD_FMT_LONG = 3'h0;
    localparam logic [2:0] FSD_FMT_SINGLE = 3'h1;
    localparam logic [2:0] FSD_FMT_EXT = 3'h2;
    localparam logic [2:0] FSD_FMT_PACKED = 3'h3;
    localparam logic [2:0] FSD_FMT_WORD = 3'h4;
    localparam logic [2:0] FSD_FMT_DOUBLE = 3'h5;
    localparam logic [2:0] FSD_FMT_BYTE = 3'h6;
    // Operand class codes written by software
    localparam logic [1:0] FSD_CLS_NORMAL = 2'h0;
    localparam logic [1:0] FSD_CLS_ZERO = 2'h1;
    localparam logic [1:0] FSD_CLS_INF = 2'h2;
    localparam logic [1:0] FSD_CLS_NAN = 2'h3;
    // Exception byte bit positions
    localparam int FSD_EX_BRANCH_UNORDERED_FLAG = 7;
    localparam int FSD_EX_SIGNALLING_NAN_FLAG = 6;
    localparam int FSD_EX_OPERAND_ERROR_FLAG = 5;
    localparam int FSD_EX_OVERFLOW_FLAG = 4;
    localparam int FSD_EX_UNDERFLOW_FLAG = 3;
    localparam int FSD_EX_DZ = 2;
    localparam int FSD_EX_INEXACT_RESULT_FLAG = 1;
    localparam int FSD_EX_INEXACT_DECIMAL_INPUT_FLAG = 0;
    // Condition code bits: N Z I NAN
    localparam int FSD_CC_N = 3;
    localparam int FSD_CC_Z = 2;
    localparam int FSD_CC_I = 1;
    localparam int FSD_CC_NAN = 0;
    localparam logic [7:0] FSD_CPID_RESET = 8'h01;
    // Interrupt events
    localparam int FSD_IRQ_DONE = 0;
    localparam int FSD_IRQ_ILLEGAL = 1;
    localparam int FSD_IRQ_OPERAND_ERROR_FLAG = 2;
    // Result class codes on the write ports
    localparam logic [2:0] FSD_RES_COMPUTED = 3'h0;
    localparam logic [2:0] FSD_RES_POS_ZERO = 3'h1;
    localparam logic [2:0] FSD_RES_NEG_ZERO = 3'h2;
    localparam logic [2:0] FSD_RES_POS_INF = 3'h3;
    localparam logic [2:0] FSD_RES_NEG_INF = 3'h4;
    localparam logic [2:0] FSD_RES_NAN = 3'h5;
    localparam logic [2:0] FSD_RES_ONE = 3'h6;
endpackage : fsd_pkg

//--- core/fsd_decode.sv
// Command decode and status update for sine-cosine and hyperbolic sine
`timescale 1ns/100ps
`default_nettype none
module fsd_decode
    import fsd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output logic src_rd_en,
    output logic [2:0] src_rd_reg,
    output logic res_wr_en,
    output logic [2:0] res_wr_reg,
    output logic [2:0] res_wr_class,
    output logic res_wr_is_sine,
    output logic res_wr_is_sinh
);
    typedef enum logic [2:0] {
        FSD_IDLE = 3'b000,
        FSD_READ = 3'b001,
        FSD_WCOS = 3'b010,
        FSD_WSIN = 3'b011,
        FSD_DONE = 3'b100
    } fsd_state_t;

    logic [15:0] opword_reg;
    logic [15:0] cmd_reg;
    logic [1:0] cls_reg;
    logic sign_reg;
    logic sine_underflow_flag_reg;
    logic hw_overflow_flag_reg;
    logic hw_underflow_flag_reg;
    logic hw_inexact_result_flag_reg;
    logic hw_inexact_decimal_input_flag_reg;
    logic signalling_nan_flag_reg;
    logic [7:0] cpid_reg;
    logic [7:0] exc_reg;
    logic [3:0] cc_reg;
    logic [7:0] quot_reg;
    logic [2:0] irq_stat_reg;
    logic [2:0] irq_mask_reg;
    logic illegal_reg;
    fsd_state_t state_reg;

    logic wr_acc;
    logic start;
    logic rm;
    logic [2:0] spec;
    logic [2:0] dst;
    logic [2:0] cos_dst;
    logic [2:0] ea_mode;
    logic [2:0] ea_reg;
    logic is_sincos;
    logic is_sinh;
    logic ea_ok;
    logic cpid_ok;
    logic legal;
    logic [2:0] sin_class;
    logic [2:0] cos_class;
    logic [7:0] exc_next;
    logic [3:0] cc_next;
    logic [2:0] ev;

    assign wr_acc = psel & penable & pwrite;
    assign start = wr_acc & (paddr == FSD_OFF_CMD) & (state_reg == FSD_IDLE);
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    // Field extraction
    assign rm = cmd_reg[FSD_RM_BIT];
    assign spec = cmd_reg[FSD_SPEC_LSB +: 3];
    assign dst = cmd_reg[FSD_DST_LSB +: 3];
    assign cos_dst = cmd_reg[FSD_COS_LSB +: 3];
    assign ea_mode = opword_reg[5:3];
    assign ea_reg = opword_reg[2:0];
    assign cpid_ok = (opword_reg[11:9] == cpid_reg[2:0]);
    assign is_sincos = (cmd_reg[15] == 1'b0) & (cmd_reg[13] == 1'b0) &
        (cmd_reg[6:3] == FSD_OPM_SINCOS);
    assign is_sinh = (cmd_reg[15] == 1'b0) & (cmd_reg[13] == 1'b0) &
        (cmd_reg[6:0] == FSD_OPM_SINH);

    // Addressing mode and format check, ignored in register mode
    always_comb begin
        ea_ok = 1'b1;
        if (rm) begin
            case (ea_mode)
                3'b001: ea_ok = 1'b0;
                3'b111: ea_ok = (ea_reg <= 3'b100);
                3'b000: ea_ok = (spec == FSD_FMT_BYTE) | (spec == FSD_FMT_WORD)
                    | (spec == FSD_FMT_LONG) | (spec == FSD_FMT_SINGLE);
                default: ea_ok = 1'b1;
            endcase
            if (spec == 3'b111) begin
                ea_ok = 1'b0;
            end
        end
    end
    assign legal = cpid_ok & ea_ok & (is_sincos | is_sinh);

    // Special value results
    always_comb begin
        sin_class = FSD_RES_COMPUTED;
        cos_class = FSD_RES_COMPUTED;
        case (cls_reg)
            FSD_CLS_ZERO: begin
                sin_class = sign_reg ? FSD_RES_NEG_ZERO : FSD_RES_POS_ZERO;
                cos_class = FSD_RES_COMPUTED;
            end
            FSD_CLS_INF: begin
                if (is_sinh) begin
                    sin_class = sign_reg ? FSD_RES_NEG_INF : FSD_RES_POS_INF;
                end else begin
                    sin_class = FSD_RES_NAN;
                    cos_class = FSD_RES_NAN;
                end
            end
            FSD_CLS_NAN: begin
                sin_class = FSD_RES_NAN;
                cos_class = FSD_RES_NAN;
            end
            default: begin
                if (sine_underflow_flag_reg) begin
                    cos_class = FSD_RES_ONE;
                end
            end
        endcase
    end

    // Exception byte and condition codes for the finished operation
    always_comb begin
        exc_next = 8'h00;
        exc_next[FSD_EX_SIGNALLING_NAN_FLAG] = signalling_nan_flag_reg;
        exc_next[FSD_EX_INEXACT_RESULT_FLAG] = hw_inexact_result_flag_reg;
        exc_next[FSD_EX_INEXACT_DECIMAL_INPUT_FLAG] = (spec == FSD_FMT_PACKED) & rm & hw_inexact_decimal_input_flag_reg;
        if (is_sinh) begin
            exc_next[FSD_EX_OVERFLOW_FLAG] = hw_overflow_flag_reg;
            exc_next[FSD_EX_UNDERFLOW_FLAG] = hw_underflow_flag_reg;
        end else begin
            exc_next[FSD_EX_OPERAND_ERROR_FLAG] = (cls_reg == FSD_CLS_INF);
            exc_next[FSD_EX_UNDERFLOW_FLAG] = sine_underflow_flag_reg &
                (cls_reg == FSD_CLS_NORMAL);
        end
        cc_next = 4'h0;
        cc_next[FSD_CC_N] = sign_reg & (cls_reg != FSD_CLS_NAN);
        cc_next[FSD_CC_Z] = (cls_reg == FSD_CLS_ZERO);
        cc_next[FSD_CC_I] = (cls_reg == FSD_CLS_INF);
        cc_next[FSD_CC_NAN] = (cls_reg == FSD_CLS_NAN);
    end

    // Software-written operation registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opword_reg <= 16'h0000;
            cmd_reg <= 16'h0000;
            cls_reg <= FSD_CLS_NORMAL;
            sign_reg <= 1'b0;
            sine_underflow_flag_reg <= 1'b0;
            hw_overflow_flag_reg <= 1'b0;
            hw_underflow_flag_reg <= 1'b0;
            hw_inexact_result_flag_reg <= 1'b0;
            hw_inexact_decimal_input_flag_reg <= 1'b0;
            signalling_nan_flag_reg <= 1'b0;
            cpid_reg <= FSD_CPID_RESET;
            irq_mask_reg <= 3'h0;
        end else if (wr_acc) begin
            case (paddr)
                FSD_OFF_OPWORD: opword_reg <= pwdata[15:0];
                FSD_OFF_CMD: if (state_reg == FSD_IDLE) cmd_reg <= pwdata[15:0];
                FSD_OFF_SRC: begin
                    cls_reg <= pwdata[1:0];
                    sign_reg <= pwdata[2];
                    sine_underflow_flag_reg <= pwdata[3];
                    hw_overflow_flag_reg <= pwdata[4];
                    hw_underflow_flag_reg <= pwdata[5];
                    hw_inexact_result_flag_reg <= pwdata[6];
                    hw_inexact_decimal_input_flag_reg <= pwdata[7];
                    signalling_nan_flag_reg <= pwdata[8];
                end
                FSD_OFF_CPID: cpid_reg <= pwdata[7:0];
                FSD_OFF_IRQ_MASK: irq_mask_reg <= pwdata[2:0];
                default: ;
            endcase
        end
    end

    // Sequencer: read source, write cosine (sine-cosine only), write sine; illegal commands skip both writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= FSD_IDLE;
        end else begin
            case (state_reg)
                FSD_IDLE: if (start) state_reg <= FSD_READ;
                FSD_READ: begin
                    if (!legal) state_reg <= FSD_DONE;
                    else if (is_sincos) state_reg <= FSD_WCOS;
                    else state_reg <= FSD_WSIN;
                end
                FSD_WCOS: state_reg <= FSD_WSIN;
                FSD_WSIN: state_reg <= FSD_DONE;
                FSD_DONE: state_reg <= FSD_IDLE;
                default: state_reg <= FSD_IDLE;
            endcase
        end
    end

    // Register file ports; the read, made only in register mode, precedes writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_rd_en <= 1'b0;
            src_rd_reg <= 3'h0;
            res_wr_en <= 1'b0;
            res_wr_reg <= 3'h0;
            res_wr_class <= FSD_RES_COMPUTED;
            res_wr_is_sine <= 1'b0;
            res_wr_is_sinh <= 1'b0;
        end else begin
            src_rd_en <= (state_reg == FSD_READ) & legal & ~rm;
            src_rd_reg <= spec;
            res_wr_en <= 1'b0;
            if (state_reg == FSD_WCOS) begin
                res_wr_en <= (cos_dst != dst);
                res_wr_reg <= cos_dst;
                res_wr_class <= cos_class;
                res_wr_is_sine <= 1'b0;
                res_wr_is_sinh <= 1'b0;
            end else if (state_reg == FSD_WSIN) begin
                res_wr_en <= 1'b1;
                res_wr_reg <= dst;
                res_wr_class <= sin_class;
                res_wr_is_sine <= 1'b1;
                res_wr_is_sinh <= is_sinh;
            end
        end
    end

    // Status register update at completion
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            exc_reg <= 8'h00;
            cc_reg <= 4'h0;
            quot_reg <= 8'h00;
            illegal_reg <= 1'b0;
        end else if (state_reg == FSD_WSIN) begin
            exc_reg <= exc_next;
            cc_reg <= cc_next;
            illegal_reg <= 1'b0;
        end else if (state_reg == FSD_READ && !legal) begin
            illegal_reg <= 1'b1;
        end
    end

    // Sticky interrupt status, set wins over write-one clear
    assign ev[FSD_IRQ_DONE] = (state_reg == FSD_DONE);
    assign ev[FSD_IRQ_ILLEGAL] = (state_reg == FSD_READ) & ~legal;
    assign ev[FSD_IRQ_OPERAND_ERROR_FLAG] = (state_reg == FSD_WSIN) & exc_next[FSD_EX_OPERAND_ERROR_FLAG];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_reg <= 3'h0;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~((wr_acc &&
                paddr == FSD_OFF_IRQ_STAT) ? pwdata[2:0] : 3'h0)) | ev;
        end
    end
    assign irq = |(irq_stat_reg & irq_mask_reg);

    // Read data mux
    always_comb begin
        case (paddr)
            FSD_OFF_OPWORD: prdata = {16'h0000, opword_reg};
            FSD_OFF_CMD: prdata = {16'h0000, cmd_reg};
            FSD_OFF_SRC: prdata = {23'h0, signalling_nan_flag_reg, hw_inexact_decimal_input_flag_reg, hw_inexact_result_flag_reg,
                hw_underflow_flag_reg, hw_overflow_flag_reg, sine_underflow_flag_reg, sign_reg, cls_reg};
            FSD_OFF_DECODE: prdata = {21'h0, state_reg, illegal_reg,
                is_sinh, is_sincos, ea_ok, rm, spec};
            FSD_OFF_FP_STATUS_REGISTER: prdata = {4'h0, cc_reg, quot_reg, exc_reg, 8'h00};
            FSD_OFF_IRQ_STAT: prdata = {29'h0, irq_stat_reg};
            FSD_OFF_IRQ_MASK: prdata = {29'h0, irq_mask_reg};
            FSD_OFF_CPID: prdata = {24'h0, cpid_reg};
            default: prdata = 32'h0000_0000;
        endcase
    end
endmodule : fsd_decode
`default_nettype wire

//--- sim/fsd_decode_checker.sv
// Port checks for the decoder
`timescale 1ns/100ps
`default_nettype none
module fsd_decode_checker
    import fsd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic irq,
    input wire logic src_rd_en,
    input wire logic [2:0] src_rd_reg,
    input wire logic res_wr_en,
    input wire logic [2:0] res_wr_reg,
    input wire logic res_wr_is_sine,
    input wire logic res_wr_is_sinh
);
    logic [15:0] cmd_reg;
    // Last command word written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_reg <= 16'h0000;
        end else if (psel && penable && pwrite && paddr == FSD_OFF_CMD) begin
            cmd_reg <= pwdata[15:0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_src_field: assert property (src_rd_en |->
        src_rd_reg == cmd_reg[12:10] && !cmd_reg[14]) else $error("src field");
    a_read_first: assert property (src_rd_en |-> ##[1:2] res_wr_en)
        else $error("read not before write");
    a_src_pulse: assert property (src_rd_en |=> !src_rd_en)
        else $error("source read not a pulse");
    a_sine_dest: assert property (res_wr_en && res_wr_is_sine |->
        res_wr_reg == cmd_reg[9:7]) else $error("sine dest");
    a_cos_dest: assert property (res_wr_en && !res_wr_is_sine |->
        res_wr_reg == cmd_reg[2:0]) else $error("cosine dest");
    a_cos_dropped: assert property (res_wr_en && !res_wr_is_sine |->
        cmd_reg[9:7] != cmd_reg[2:0]) else $error("cosine not dropped");
    a_cos_then_sine: assert property (res_wr_en && !res_wr_is_sine |=>
        res_wr_en && res_wr_is_sine) else $error("sine missing");
    a_sinh_opmode: assert property (res_wr_en && res_wr_is_sinh |->
        res_wr_is_sine && cmd_reg[6:0] == FSD_OPM_SINH && !cmd_reg[15]
        && !cmd_reg[13]) else $error("sinh opmode");
    a_sincos_opmode: assert property (res_wr_en && !res_wr_is_sinh |->
        cmd_reg[6:3] == FSD_OPM_SINCOS) else $error("sincos opmode");
    a_sinh_single: assert property (res_wr_en && res_wr_is_sinh |=>
        !res_wr_en) else $error("sinh double write");
    c_cos: cover property (res_wr_en && !res_wr_is_sine);
    c_sinh: cover property (res_wr_en && res_wr_is_sinh);
    c_irq: cover property ($rose(irq));
endmodule : fsd_decode_checker
bind fsd_decode fsd_decode_checker u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .irq(irq), .src_rd_en(src_rd_en),
    .src_rd_reg(src_rd_reg), .res_wr_en(res_wr_en), .res_wr_reg(res_wr_reg),
    .res_wr_is_sine(res_wr_is_sine), .res_wr_is_sinh(res_wr_is_sinh));
`default_nettype wire

//--- sim/fsd_fpreg_model.sv
// Floating-point register file on the far side of the decoder
`timescale 1ns/100ps
`default_nettype none
module fsd_fpreg_model
    import fsd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clr,
    input wire logic src_rd_en,
    input wire logic res_wr_en,
    input wire logic [2:0] res_wr_reg,
    input wire logic [2:0] res_wr_class,
    input wire logic res_wr_is_sine,
    output logic [3:0] nwr,
    output logic [3:0] nrd,
    output logic [7:0][2:0] cls,
    output logic [7:0] sine_mask,
    output logic order_bad
);
    // Count reads and writes, keep result classes
    always_ff @(posedge pclk) begin
        if (!presetn || clr) begin
            nwr <= 4'h0;
            nrd <= 4'h0;
            cls <= '0;
            sine_mask <= 8'h00;
            order_bad <= 1'b0;
        end else begin
            if (src_rd_en) begin
                nrd <= nrd + 4'h1;
                order_bad <= order_bad | (nwr != 4'h0);
            end
            if (res_wr_en) begin
                nwr <= nwr + 4'h1;
                cls[res_wr_reg] <= res_wr_class;
                if (res_wr_is_sine) begin
                    sine_mask[res_wr_reg] <= 1'b1;
                end
            end
        end
    end
endmodule : fsd_fpreg_model
`default_nettype wire

//--- sim/test_fp_sincos_sinh_decode.sv
// Self-checking bench for the decoder
`timescale 1ns/100ps
`default_nettype none
module test_fp_sincos_sinh_decode
    import fsd_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic clr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, q;
    logic pready, pslverr, irq, src_rd_en, res_wr_en, is_sine, is_sinh;
    logic [2:0] src_rd_reg, res_wr_reg, res_wr_class;
    logic [3:0] nwr, nrd;
    logic [7:0][2:0] cls;
    logic [7:0] sine_mask;
    logic order_bad;
    int fails = 0;
    int checked = 0;
    int cyc = 0;
    always #5 pclk = ~pclk;
    fsd_decode dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .src_rd_en(src_rd_en), .src_rd_reg(src_rd_reg), .res_wr_en(res_wr_en),
        .res_wr_reg(res_wr_reg), .res_wr_class(res_wr_class),
        .res_wr_is_sine(is_sine), .res_wr_is_sinh(is_sinh));
    fsd_fpreg_model pm (.pclk(pclk), .presetn(presetn), .clr(clr),
        .src_rd_en(src_rd_en), .res_wr_en(res_wr_en), .res_wr_reg(res_wr_reg),
        .res_wr_class(res_wr_class), .res_wr_is_sine(is_sine), .nwr(nwr),
        .nrd(nrd), .cls(cls), .sine_mask(sine_mask), .order_bad(order_bad));
    // One APB transfer, result left in q
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s exp %h got %h", n, e, g);
        end
    endtask : chk
    function automatic logic [15:0] ow(input logic [2:0] c, m, r);
        return {4'hF, c, 3'h0, m, r};
    endfunction : ow
    function automatic logic [15:0] sc(input logic rm, input logic [2:0] s, n, c);
        return {1'b0, rm, 1'b0, s, n, FSD_OPM_SINCOS, c};
    endfunction : sc
    function automatic logic [15:0] sh(input logic rm, input logic [2:0] s, n);
        return {1'b0, rm, 1'b0, s, n, FSD_OPM_SINH};
    endfunction : sh
    // Load, start, wait for done or illegal; q holds the status
    task automatic run_op(input logic [15:0] o, input logic [8:0] s,
        input logic [15:0] c);
        apb(1'b1, FSD_OFF_IRQ_STAT, 32'h7);
        apb(1'b1, FSD_OFF_OPWORD, {16'h0, o});
        apb(1'b1, FSD_OFF_SRC, {23'h0, s});
        clr <= 1'b1;
        @(posedge pclk);
        clr <= 1'b0;
        apb(1'b1, FSD_OFF_CMD, {16'h0, c});
        q = 32'h0;
        for (int i = 0; i < 20 && q[1:0] == 2'h0; i++) begin
            apb(1'b0, FSD_OFF_IRQ_STAT, 32'h0);
        end
        // Poll limit running out counts as a mismatch
        chk("op end", 32'h1, q[1:0] != 2'h0);
    endtask : run_op
    task automatic t_sincos();
        run_op(ow(3'h1, 3'h0, 3'h0), 9'h002, sc(1'b0, 3'h1, 3'h3, 3'h2));
        chk("operand_error_flag irq", 32'h1, q[2]);
        chk("nan", {4'h2, 3'h5, 3'h5}, {nwr, cls[3], cls[2]});
        apb(1'b0, FSD_OFF_FP_STATUS_REGISTER, 32'h0);
        chk("operand_error_flag", 32'h1, q[13]);
        run_op(ow(3'h1, 3'h0, 3'h0), 9'h008, sc(1'b0, 3'h2, 3'h3, 3'h2));
        chk("cos one", FSD_RES_ONE, cls[2]);
        chk("read first", 32'h0, order_bad);
        apb(1'b0, FSD_OFF_FP_STATUS_REGISTER, 32'h0);
        chk("underflow_flag operand_error_flag", 32'h2, {q[11], q[13]});
        run_op(ow(3'h1, 3'h0, 3'h0), 9'h000, sc(1'b0, 3'h1, 3'h4, 3'h4));
        chk("same dst", {4'h1, 8'h10}, {nwr, sine_mask});
    endtask : t_sincos
    task automatic t_formats();
        for (int f = 0; f < 8; f++) begin
            run_op(ow(3'h1, 3'h2, 3'h1), 9'h080, sc(1'b1, f[2:0], 3'h5, 3'h6));
            chk("mem op", {4'h0, (f == 7) ? 4'h0 : 4'h2}, {nrd, nwr});
            apb(1'b0, FSD_OFF_DECODE, 32'h0);
            chk("spec", {f == 7, 1'b1, f[2:0]}, {q[7], q[3], q[2:0]});
            apb(1'b0, FSD_OFF_FP_STATUS_REGISTER, 32'h0);
            chk("inexact_decimal_input_flag", f == 3, q[8]);
        end
    endtask : t_formats
    task automatic t_ea();
        for (int m = 0; m < 8; m++) begin
            for (int r = 0; r < 8; r++) begin
                run_op(ow(3'h1, m[2:0], r[2:0]), 9'h000,
                    sc(1'b1, FSD_FMT_SINGLE, 3'h1, 3'h0));
                apb(1'b0, FSD_OFF_DECODE, 32'h0);
                chk("ea ok", !(m == 1 || (m == 7 && r > 4)), q[4]);
            end
        end
        run_op(ow(3'h1, 3'h0, 3'h0), 9'h000,
            sc(1'b1, FSD_FMT_DOUBLE, 3'h1, 3'h0));
        apb(1'b0, FSD_OFF_DECODE, 32'h0);
        chk("dn fmt", 32'h0, q[4]);
        run_op(ow(3'h2, 3'h0, 3'h0), 9'h000, sc(1'b0, 3'h1, 3'h1, 3'h0));
        chk("cpid bad", {1'b1, 4'h0}, {q[1], nwr});
        apb(1'b1, FSD_OFF_CPID, 32'h2);
        run_op(ow(3'h2, 3'h0, 3'h0), 9'h000, sc(1'b0, 3'h1, 3'h1, 3'h0));
        chk("cpid ok", 32'h2, nwr);
        apb(1'b1, FSD_OFF_CPID, 32'h1);
    endtask : t_ea
    task automatic t_sinh();
        logic [2:0] ec [4] = '{FSD_RES_POS_ZERO, FSD_RES_NEG_ZERO,
            FSD_RES_POS_INF, FSD_RES_NEG_INF};
        logic [3:0] cc [4] = '{4'h4, 4'hC, 4'h2, 4'hA};
        for (int i = 0; i < 4; i++) begin
            run_op(ow(3'h1, 3'h0, 3'h0), 9'h002, sc(1'b0, 3'h1, 3'h3, 3'h2));
            run_op(ow(3'h1, 3'h0, 3'h0), {6'h0, i[0],
                (i < 2) ? FSD_CLS_ZERO : FSD_CLS_INF}, sh(1'b0, 3'h5, 3'h6));
            chk("sinh", {4'h1, ec[i]}, {nwr, cls[6]});
            apb(1'b0, FSD_OFF_FP_STATUS_REGISTER, 32'h0);
            chk("cc", cc[i], q[27:24]);
            chk("exc", 32'h0, {q[15], q[13], q[10], q[23:16]});
        end
        run_op(ow(3'h1, 3'h0, 3'h0), 9'h000, sh(1'b0, 3'h1, 3'h2) | 16'h8000);
        chk("bit15", {1'b1, 4'h0}, {q[1], nwr});
    endtask : t_sinh
    task automatic t_irq();
        apb(1'b1, FSD_OFF_IRQ_MASK, 32'h1);
        run_op(ow(3'h1, 3'h0, 3'h0), 9'h000, sh(1'b0, 3'h1, 3'h2));
        @(negedge pclk);
        chk("irq on", 32'h1, irq);
        apb(1'b1, FSD_OFF_IRQ_STAT, 32'h1);
        @(negedge pclk);
        chk("irq off", 32'h0, irq);
        apb(1'b1, FSD_OFF_IRQ_MASK, 32'h0);
        run_op(ow(3'h1, 3'h0, 3'h0), 9'h000, sh(1'b0, 3'h1, 3'h2));
        @(negedge pclk);
        chk("irq masked", 32'h0, irq);
    endtask : t_irq
    task automatic end_sim();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim
    // Main sequence
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, FSD_OFF_CPID, 32'h0);
        chk("cpid rst", 32'h1, q);
        apb(1'b0, FSD_OFF_EA, 32'h0);
        chk("unmapped", 32'h0, q);
        chk("slverr", 32'h0, pslverr);
        t_sincos();
        t_formats();
        t_ea();
        t_sinh();
        t_irq();
        end_sim();
    end
    // Hang guard
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 30000) begin
            fails++;
            end_sim();
        end
    end
endmodule : test_fp_sincos_sinh_decode
`default_nettype wire
